// File: ingress_rules_pkg.sv
/*
  Constants for the switch port ingress rule block: register indices, field
  positions, reset values and the spanning tree state encoding.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
// Operation
// - Learn source only if enabled and forwarding/learning.
// - Learning enable bits 5,4,3 map ports 2,1,0.
// - Drop non-member ingress unless non-member admit set.
// - Known destination: also drop non-member egress port.
// - Unknown destination: check ingress membership only.
// - Membership checking needs global VLAN enable.
// - Tagged-only ports drop untagged and priority-tagged frames.
// - Tagged-only admission needs global VLAN enable.
// - Two-bit spanning state, resets to forwarding.
// - State fields at bits 5:4, 3:2, 1:0.
// - Priorities 0-7 map to queues via two-bit fields.
// - Traffic class map reset value 0xfa41.
// - Global VLAN enable is bit 0, global config.
// - Non-member admit accepts frames of active VLANs.
package ingress_rules_pkg;

  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [15:0] IDX_GLOBAL_INGRESS = 16'h1840;
  localparam logic [15:0] IDX_PORT_INGRESS = 16'h1841;
  localparam logic [15:0] IDX_TAGGED_ONLY = 16'h1842;
  localparam logic [15:0] IDX_STP_STATE = 16'h1843;
  localparam logic [15:0] IDX_PRIO_QUEUE = 16'h1845;
  localparam logic [15:0] IDX_NON_MEMBER = 16'h1849;
  localparam int ADDR_W = 18;
  localparam int PORTS = 3;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int LEARN_LSB = 3;
  localparam int MEMBER_LSB = 0;
  localparam int VLAN_EN_BIT = 0;
  localparam logic [5:0] PORT_INGRESS_RESET = 6'h38;
  localparam logic [2:0] TAGGED_ONLY_RESET = 3'h0;
  localparam logic [5:0] STP_STATE_RESET = 6'h00;
  localparam logic [15:0] PRIO_QUEUE_RESET = 16'hfa41;
  localparam logic [2:0] NON_MEMBER_RESET = 3'h0;
  localparam logic GLOBAL_VLAN_RESET = 1'b0;

  typedef enum logic [1:0] {
    STP_FORWARDING = 2'b00,
    STP_BLOCKING = 2'b01,
    STP_LEARNING = 2'b10,
    STP_DISABLED = 2'b11
  } stp_state_type;

endpackage : ingress_rules_pkg

// File: switch_port_ingress_rules.sv
/*
  Per-port ingress rule configuration and frame decision logic for a
  three-port switch: APB register slave plus registered admit, learn and
  queue outputs for the frame currently presented by the forwarding engine.
  Assumes the frame descriptor inputs come from logic on the same clock.
*/
`timescale 1ns/1ns
module switch_port_ingress_rules (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [17:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Frame descriptor
  input wire logic [1:0] ingress_port_i,
  input wire logic [1:0] egress_port_i,
  input wire logic vlan_tagged_i,
  input wire logic priority_tag_only_i,
  input wire logic [2:0] vlan_members_i,
  input wire logic vlan_active_i,
  input wire logic address_lookup_table_hit_i,
  input wire logic [2:0] frame_priority_i,
  // Frame decision
  output logic frame_drop_o,
  output logic learn_source_o,
  output logic [1:0] egress_queue_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic global_vlan_en;
  logic [5:0] port_ingress_config;
  logic [2:0] tagged_only_admit;
  logic [5:0] spanning_tree_port_state;
  logic [15:0] priority_queue_map;
  logic [2:0] non_member_admit;
  logic next_global_vlan_en;
  logic [5:0] next_port_ingress_config;
  logic [2:0] next_tagged_only_admit;
  logic [5:0] next_spanning_tree_port_state;
  logic [15:0] next_priority_queue_map;
  logic [2:0] next_non_member_admit;
  logic [31:0] next_prdata;
  logic [31:0] rd_word;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [15:0] idx;

  // Address is a byte address; word index is the upper bits.
  assign idx = paddr_i[17:2];
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  // The slave never stalls; reads are registered in the setup cycle.
  assign pready_o = 1'b1;

  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0;
    case (idx)
      ingress_rules_pkg::IDX_GLOBAL_INGRESS: rd_word = {31'h0, global_vlan_en};
      ingress_rules_pkg::IDX_PORT_INGRESS: rd_word = {26'h0, port_ingress_config};
      ingress_rules_pkg::IDX_TAGGED_ONLY: rd_word = {29'h0, tagged_only_admit};
      ingress_rules_pkg::IDX_STP_STATE: rd_word = {26'h0, spanning_tree_port_state};
      ingress_rules_pkg::IDX_PRIO_QUEUE: rd_word = {16'h0, priority_queue_map};
      ingress_rules_pkg::IDX_NON_MEMBER: rd_word = {29'h0, non_member_admit};
      default: hit = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error and read zero.
  assign pslverr_o = psel_i && penable_i && !hit;

  always_comb begin
    next_global_vlan_en = global_vlan_en;
    next_port_ingress_config = port_ingress_config;
    next_tagged_only_admit = tagged_only_admit;
    next_spanning_tree_port_state = spanning_tree_port_state;
    next_priority_queue_map = priority_queue_map;
    next_non_member_admit = non_member_admit;
    next_prdata = rd_en ? rd_word : prdata_o;
    if (wr_en) begin
      case (idx)
        ingress_rules_pkg::IDX_GLOBAL_INGRESS:
          next_global_vlan_en = pwdata_i[ingress_rules_pkg::VLAN_EN_BIT];
        ingress_rules_pkg::IDX_PORT_INGRESS: next_port_ingress_config = pwdata_i[5:0];
        ingress_rules_pkg::IDX_TAGGED_ONLY: next_tagged_only_admit = pwdata_i[2:0];
        ingress_rules_pkg::IDX_STP_STATE: next_spanning_tree_port_state = pwdata_i[5:0];
        ingress_rules_pkg::IDX_PRIO_QUEUE: next_priority_queue_map = pwdata_i[15:0];
        ingress_rules_pkg::IDX_NON_MEMBER: next_non_member_admit = pwdata_i[2:0];
        default: next_global_vlan_en = global_vlan_en;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      global_vlan_en <= ingress_rules_pkg::GLOBAL_VLAN_RESET;
      port_ingress_config <= ingress_rules_pkg::PORT_INGRESS_RESET;
      tagged_only_admit <= ingress_rules_pkg::TAGGED_ONLY_RESET;
      spanning_tree_port_state <= ingress_rules_pkg::STP_STATE_RESET;
      priority_queue_map <= ingress_rules_pkg::PRIO_QUEUE_RESET;
      non_member_admit <= ingress_rules_pkg::NON_MEMBER_RESET;
      prdata_o <= 32'h0;
    end else begin
      global_vlan_en <= next_global_vlan_en;
      port_ingress_config <= next_port_ingress_config;
      tagged_only_admit <= next_tagged_only_admit;
      spanning_tree_port_state <= next_spanning_tree_port_state;
      priority_queue_map <= next_priority_queue_map;
      non_member_admit <= next_non_member_admit;
      prdata_o <= next_prdata;
    end
  end

  // ----------------------------------------
  // Frame decision
  // ----------------------------------------
  function automatic logic port_bit(input logic [2:0] vec, input logic [1:0] port);
    port_bit = (port < 2'h3) ? vec[port] : 1'b0;
  endfunction : port_bit

  logic [1:0] in_state;
  logic in_member;
  logic out_member;
  logic check_member;
  logic member_drop;
  logic tag_drop;
  logic [2:0] learn_en;
  logic [2:0] member_en;

  // Enable fields hold one bit per port, port 0 in the lowest bit.
  assign learn_en =
    port_ingress_config[ingress_rules_pkg::LEARN_LSB +: ingress_rules_pkg::PORTS];
  assign member_en =
    port_ingress_config[ingress_rules_pkg::MEMBER_LSB +: ingress_rules_pkg::PORTS];

  always_comb begin
    case (ingress_port_i)
      2'h0: in_state = spanning_tree_port_state[1:0];
      2'h1: in_state = spanning_tree_port_state[3:2];
      2'h2: in_state = spanning_tree_port_state[5:4];
      default: in_state = ingress_rules_pkg::STP_DISABLED;
    endcase
  end

  assign in_member = port_bit(vlan_members_i, ingress_port_i);
  assign out_member = port_bit(vlan_members_i, egress_port_i);
  assign check_member = global_vlan_en
    && port_bit(member_en, ingress_port_i);
  assign member_drop = check_member && (
    (!in_member && !(port_bit(non_member_admit, ingress_port_i) && vlan_active_i))
    || (address_lookup_table_hit_i && !out_member));
  assign tag_drop = global_vlan_en && port_bit(tagged_only_admit, ingress_port_i)
    && (!vlan_tagged_i || priority_tag_only_i);

  logic next_drop;
  logic next_learn;
  logic [1:0] next_queue;

  always_comb begin
    next_drop = member_drop || tag_drop;
    next_learn = port_bit(learn_en, ingress_port_i)
      && (in_state == ingress_rules_pkg::STP_FORWARDING
      || in_state == ingress_rules_pkg::STP_LEARNING);
    next_queue = priority_queue_map[{frame_priority_i, 1'b0} +: 2];
  end

  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      frame_drop_o <= 1'b0;
      learn_source_o <= 1'b0;
      egress_queue_o <= 2'h0;
    end else begin
      frame_drop_o <= next_drop;
      learn_source_o <= next_learn;
      egress_queue_o <= next_queue;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_learn_gate;
    @(posedge clk_i) disable iff (!rst_sync)
    (in_state == ingress_rules_pkg::STP_BLOCKING || in_state == ingress_rules_pkg::STP_DISABLED)
      |=> !learn_source_o;
  endproperty
  a_learn_gate: assert property (p_learn_gate) else $error("learning in bad state");

  property p_vlan_off;
    @(posedge clk_i) disable iff (!rst_sync)
    !global_vlan_en |=> !frame_drop_o;
  endproperty
  a_vlan_off: assert property (p_vlan_off) else $error("drop without vlan enable");

  property p_tag_drop;
    @(posedge clk_i) disable iff (!rst_sync)
    (global_vlan_en && ingress_port_i == 2'h1 && tagged_only_admit[1] && !vlan_tagged_i)
      |=> frame_drop_o;
  endproperty
  a_tag_drop: assert property (p_tag_drop) else $error("untagged frame kept");

  property p_egress;
    @(posedge clk_i) disable iff (!rst_sync)
    (check_member && address_lookup_table_hit_i && !out_member) |=> frame_drop_o;
  endproperty
  a_egress: assert property (p_egress) else $error("egress non-member kept");

  property p_miss;
    @(posedge clk_i) disable iff (!rst_sync)
    (!address_lookup_table_hit_i && in_member && !tag_drop) |=> !frame_drop_o;
  endproperty
  a_miss: assert property (p_miss) else $error("egress checked on miss");

  property p_queue;
    @(posedge clk_i) disable iff (!rst_sync)
    (frame_priority_i == 3'h7) |=> (egress_queue_o == $past(priority_queue_map[15:14]));
  endproperty
  a_queue: assert property (p_queue) else $error("priority 7 queue wrong");

  property p_reset_map;
    @(posedge clk_i) $rose(rst_sync) |-> priority_queue_map == 16'hfa41;
  endproperty
  a_reset_map: assert property (p_reset_map) else $error("class map reset wrong");

  property p_reserved;
    @(posedge clk_i) disable iff (!rst_sync)
    (psel_i && !penable_i && !pwrite_i && idx == ingress_rules_pkg::IDX_STP_STATE)
      |=> prdata_o[31:6] == 26'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  // Mapped registers always answer at once and without error.
  sequence s_mapped_access;
    psel_i && penable_i && (idx == ingress_rules_pkg::IDX_GLOBAL_INGRESS
      || idx == ingress_rules_pkg::IDX_PORT_INGRESS || idx == ingress_rules_pkg::IDX_TAGGED_ONLY
      || idx == ingress_rules_pkg::IDX_STP_STATE || idx == ingress_rules_pkg::IDX_PRIO_QUEUE
      || idx == ingress_rules_pkg::IDX_NON_MEMBER);
  endsequence

  property p_mapped_ok;
    @(posedge clk_i) disable iff (!rst_sync)
    s_mapped_access |-> pready_o && !pslverr_o;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");

  sequence s_global_write;
    psel_i && penable_i && pwrite_i && idx == ingress_rules_pkg::IDX_GLOBAL_INGRESS;
  endsequence

  property p_global_write;
    @(posedge clk_i) disable iff (!rst_sync)
    s_global_write |=> global_vlan_en == $past(pwdata_i[ingress_rules_pkg::VLAN_EN_BIT]);
  endproperty
  a_global_write: assert property (p_global_write) else $error("vlan enable lost");

  sequence s_foreign_refused;
    check_member && !in_member && !port_bit(non_member_admit, ingress_port_i);
  endsequence

  sequence s_foreign_admitted;
    check_member && !in_member && port_bit(non_member_admit, ingress_port_i)
      && vlan_active_i && !address_lookup_table_hit_i && !tag_drop;
  endsequence

  property p_ingress_drop;
    @(posedge clk_i) disable iff (!rst_sync)
    s_foreign_refused |=> frame_drop_o;
  endproperty
  a_ingress_drop: assert property (p_ingress_drop) else $error("non-member kept");

  property p_admit;
    @(posedge clk_i) disable iff (!rst_sync)
    s_foreign_admitted |=> !frame_drop_o;
  endproperty
  a_admit: assert property (p_admit) else $error("admitted non-member dropped");

  property p_learn_port2;
    @(posedge clk_i) disable iff (!rst_sync)
    (ingress_port_i == 2'h2 && port_ingress_config[5]
      && spanning_tree_port_state[5:4] == ingress_rules_pkg::STP_FORWARDING) |=> learn_source_o;
  endproperty
  a_learn_port2: assert property (p_learn_port2) else $error("port 2 learning missed");

  property p_block_port1;
    @(posedge clk_i) disable iff (!rst_sync)
    (ingress_port_i == 2'h1 && spanning_tree_port_state[3:2] == ingress_rules_pkg::STP_BLOCKING)
      |=> !learn_source_o;
  endproperty
  a_block_port1: assert property (p_block_port1) else $error("port 1 blocked learn");

  property p_queue0;
    @(posedge clk_i) disable iff (!rst_sync)
    (frame_priority_i == 3'h0) |=> (egress_queue_o == $past(priority_queue_map[1:0]));
  endproperty
  a_queue0: assert property (p_queue0) else $error("priority 0 queue wrong");

  property p_reset_state;
    @(posedge clk_i) $rose(rst_sync) |-> spanning_tree_port_state == 6'h00
      && port_ingress_config == 6'h38;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("port state reset wrong");

  sequence s_map_read_setup;
    psel_i && !penable_i && !pwrite_i && idx == ingress_rules_pkg::IDX_PRIO_QUEUE;
  endsequence

  property p_map_read;
    @(posedge clk_i) disable iff (!rst_sync)
    s_map_read_setup |=> prdata_o == {16'h0, $past(priority_queue_map)};
  endproperty
  a_map_read: assert property (p_map_read) else $error("class map read wrong");

  property p_tag_off;
    @(posedge clk_i) disable iff (!rst_sync)
    (!global_vlan_en && tagged_only_admit != 3'h0) |=> !frame_drop_o;
  endproperty
  a_tag_off: assert property (p_tag_off) else $error("tag filter without enable");

endmodule : switch_port_ingress_rules

// File: switch_port_ingress_rules_tb_top.sv
/*
  Self-checking bench for the switch port ingress rule block: APB register
  access, reset values, learning, membership, tagged-only and queue map.
  Assumes zero-wait APB and frame decisions registered one cycle late.
*/
`timescale 1ns/1ns
module switch_port_ingress_rules_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, drop, learn;
  logic [1:0] ing = 2'h0, egr = 2'h0, queue;
  logic tag = 1'b0, ptag = 1'b0, act = 1'b0, hit = 1'b0;
  logic [2:0] mem = 3'h0, prio = 3'h0;
  logic [15:0] map;
  int num_errors = 0;
  int compares = 0;

  always #25 clk = ~clk;

  switch_port_ingress_rules i_switch_port_ingress_rules (
    .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ingress_port_i(ing),
    .egress_port_i(egr), .vlan_tagged_i(tag), .priority_tag_only_i(ptag),
    .vlan_members_i(mem), .vlan_active_i(act), .address_lookup_table_hit_i(hit),
    .frame_priority_i(prio), .frame_drop_o(drop), .learn_source_o(learn),
    .egress_queue_o(queue));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; the byte address is four times the register index.
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask : apb

  task send(input logic [1:0] i, input logic [1:0] e, input logic t, input logic pt,
            input logic [2:0] m, input logic a, input logic h, input logic [2:0] p);
    @(posedge clk);
    ing <= i;
    egr <= e;
    tag <= t;
    ptag <= pt;
    mem <= m;
    act <= a;
    hit <= h;
    prio <= p;
    @(posedge clk);
    #1;
  endtask : send

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, ingress_rules_pkg::IDX_PORT_INGRESS, 0); check("port_ingress", rd, 32'h38);
    apb(0, ingress_rules_pkg::IDX_TAGGED_ONLY, 0); check("tagged_only", rd, 32'h0);
    apb(0, ingress_rules_pkg::IDX_STP_STATE, 0); check("stp_state", rd, 32'h0);
    apb(0, ingress_rules_pkg::IDX_PRIO_QUEUE, 0); check("prio_map", rd, 32'hfa41);
    apb(0, ingress_rules_pkg::IDX_NON_MEMBER, 0); check("non_member", rd, 32'h0);
    apb(0, ingress_rules_pkg::IDX_GLOBAL_INGRESS, 0); check("global", rd, 32'h0);
    check("global_err", err, 0);
    apb(1, ingress_rules_pkg::IDX_TAGGED_ONLY, 32'hffffffff);
    apb(0, ingress_rules_pkg::IDX_TAGGED_ONLY, 0); check("reserved", rd, 32'h7);
    apb(1, 16'h1844, 32'hffffffff); check("unmapped_err", err, 1);
    apb(0, 16'h1844, 0); check("unmapped_rd", rd, 0);
    apb(1, ingress_rules_pkg::IDX_TAGGED_ONLY, 0);
    $display("Register reset and reserved test done");
    // Queue map from reset, then from a map sending priorities 0-3 to queues 0-3 and 4-7 to queues 3-0.
    map = 16'hfa41;
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 8; p++) begin
        send(0, 0, 1, 0, 3'h7, 1, 0, p[2:0]);
        check("queue", queue, map[2*p +: 2]);
      end
      map = 16'h1be4;
      apb(1, ingress_rules_pkg::IDX_PRIO_QUEUE, {16'h0, map});
    end
    $display("Queue map test done");
    // Learning with ports 2 and 0 enabled, in every spanning state.
    apb(1, ingress_rules_pkg::IDX_PORT_INGRESS, 32'h28);
    for (int s = 0; s < 4; s++) begin
      apb(1, ingress_rules_pkg::IDX_STP_STATE, {26'h0, s[1:0], s[1:0], s[1:0]});
      apb(0, ingress_rules_pkg::IDX_STP_STATE, 0); check("stp", rd[5:0], {3{s[1:0]}});
      for (int p = 0; p < 3; p++) begin
        send(p[1:0], 0, 1, 0, 3'h7, 1, 0, 0);
        check("learn", learn, p != 1 && (s == 0 || s == 2));
      end
    end
    apb(1, ingress_rules_pkg::IDX_STP_STATE, 0);
    $display("Learning test done");
    // Membership checking on port 0.
    apb(1, ingress_rules_pkg::IDX_PORT_INGRESS, 32'h39);
    send(0, 1, 1, 0, 3'b110, 1, 0, 0); check("drop_gl_off", drop, 0);
    apb(1, ingress_rules_pkg::IDX_GLOBAL_INGRESS, 32'h1);
    send(0, 1, 1, 0, 3'b110, 1, 0, 0); check("drop_nonmem", drop, 1);
    apb(1, ingress_rules_pkg::IDX_NON_MEMBER, 32'h1);
    send(0, 1, 1, 0, 3'b110, 1, 0, 0); check("drop_admit", drop, 0);
    send(0, 1, 1, 0, 3'b110, 0, 0, 0); check("drop_inact", drop, 1);
    apb(1, ingress_rules_pkg::IDX_NON_MEMBER, 0);
    send(0, 1, 1, 0, 3'b001, 1, 1, 0); check("drop_egress", drop, 1);
    send(0, 1, 1, 0, 3'b001, 1, 0, 0); check("drop_miss", drop, 0);
    $display("Membership test done");
    // Tagged-only admission on port 1.
    apb(1, ingress_rules_pkg::IDX_PORT_INGRESS, 32'h38);
    apb(1, ingress_rules_pkg::IDX_TAGGED_ONLY, 32'h2);
    send(1, 0, 0, 0, 3'h0, 1, 0, 0); check("drop_untag", drop, 1);
    send(1, 0, 1, 1, 3'h0, 1, 0, 0); check("drop_ptag", drop, 1);
    send(1, 0, 1, 0, 3'h0, 1, 0, 0); check("drop_tag", drop, 0);
    send(0, 0, 0, 0, 3'h0, 1, 0, 0); check("drop_port0", drop, 0);
    apb(1, ingress_rules_pkg::IDX_GLOBAL_INGRESS, 0);
    send(1, 0, 0, 0, 3'h0, 1, 0, 0); check("drop_untag_off", drop, 0);
    $display("Tagged-only test done");
    // Reset again in mid-run: learn clears, and the map, port and tagged-only registers return to reset values.
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check("learn_in_reset", learn, 0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, ingress_rules_pkg::IDX_PRIO_QUEUE, 0); check("prio_rst", rd, 32'hfa41);
    apb(0, ingress_rules_pkg::IDX_PORT_INGRESS, 0); check("port_rst", rd, 32'h38);
    apb(0, ingress_rules_pkg::IDX_TAGGED_ONLY, 0); check("tagged_rst", rd, 32'h0);
    $display("Mid-run reset test done");
    end_sim();
  end
endmodule : switch_port_ingress_rules_tb_top
